// [design/card_host_pkg.sv]
// Shared constants and signal bundles for the card host interface.
package card_host_pkg;

  // Master clock rate and period.
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam int unsigned MCLK_PERIOD_NS = 10;
  // Smallest card clock divisor: the card clock is at most half the rate.
  localparam int unsigned CARD_CLK_MIN_DIV = 2;
  // Bits in one command or short response frame.
  localparam logic [5:0] CMD_BITS = 6'h30;
  // Bits in one data word exchanged with the DMA channel.
  localparam logic [5:0] WORD_BITS = 6'h20;
  // Default supervision windows, counted in card clock rising edges.
  localparam logic [15:0] RSP_TIMEOUT_TICKS = 16'h0040;
  localparam logic [15:0] DATA_TIMEOUT_TICKS = 16'h0400;
  // Depth of the data buffer in words.
  localparam int unsigned FIFO_DEPTH = 32;
  // Codes of the slot select field.
  localparam logic [1:0] SLOT_A = 2'h0;
  localparam logic [1:0] SLOT_B = 2'h1;
  // Reset value of the card clock divider count.
  localparam logic [7:0] CLK_DIV_RESET = 8'h00;

  // Kind of response that a command expects.
  typedef enum logic [1:0] {
    RSP_NONE  = 2'h0,
    RSP_CRC   = 2'h1,
    RSP_NOCRC = 2'h2
  } rsp_kind_type;

  // Kind of data transfer that follows a command.
  typedef enum logic [1:0] {
    XFER_SINGLE = 2'h0,
    XFER_MULTI  = 2'h1,
    XFER_STREAM = 2'h2
  } xfer_kind_type;

  // One command as software hands it over.
  typedef struct packed {
    logic [5:0] index;
    logic [31:0] arg;
    rsp_kind_type rsp;
    logic open_drain;
    logic xfer;
    logic xfer_write;
    xfer_kind_type kind;
    logic [15:0] blk_words;
    logic [15:0] blk_count;
  } cmd_req_type;

  // Pin drive toward one slot: output level and output enable per line.
  typedef struct packed {
    logic cmd_o;
    logic cmd_oe;
    logic [3:0] dat_o;
    logic [3:0] dat_oe;
  } slot_out_type;

  // Pin levels seen from one slot.
  typedef struct packed {
    logic cmd_i;
    logic [3:0] dat_i;
  } slot_in_type;

  // Status flags; done and error flags are one-cycle pulses.
  typedef struct packed {
    logic busy;
    logic cmd_done;
    logic rsp_timeout;
    logic rsp_crc_err;
    logic data_timeout;
    logic data_done;
  } status_type;

endpackage

// [design/fifo_buf.sv]
// Word buffer with valid and ready on both sides.
module fifo_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // Pointer width; DEPTH must be a power of two.
  localparam int AW = $clog2(DEPTH);

  // Storage words, not reset.
  logic [WIDTH-1:0] mem_q [DEPTH];
  // Pointers with one wrap bit above the index.
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  // Full when the indices meet with differing wrap bits.
  assign in_ready = !((wr_q[AW] != rd_q[AW]) &&
                      (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem_q[rd_q[AW-1:0]];

  // Stores a word whenever the filling side hands one over.
  always_ff @(posedge mclk) begin
    if (in_valid && in_ready) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Advances the pointers on accepted transfers.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// [design/card_host_interface.sv]
// Card host interface: command, response and data engine for two slots.
module card_host_interface #(
  parameter logic [15:0] RSP_TIMEOUT = card_host_pkg::RSP_TIMEOUT_TICKS,
  parameter logic [15:0] DATA_TIMEOUT = card_host_pkg::DATA_TIMEOUT_TICKS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic interface_enable_bit,
  input wire logic [7:0] clk_div,
  input wire logic [1:0] slot_sel,
  input wire logic sd_mode,
  input wire logic bus_width_select,
  input wire logic cmd_start,
  input wire card_host_pkg::cmd_req_type cmd_req,
  input wire logic stop_req,
  output card_host_pkg::status_type status,
  output logic [47:0] resp,
  input wire logic dma_wr_valid,
  output logic dma_wr_ready,
  input wire logic [31:0] dma_wr_data,
  output logic dma_rd_valid,
  input wire logic dma_rd_ready,
  output logic [31:0] dma_rd_data,
  output logic card_irq,
  output logic card_detect_a,
  output logic card_detect_b,
  output logic card_bus_clock_pin,
  output card_host_pkg::slot_out_type slot_a_out,
  input wire card_host_pkg::slot_in_type slot_a_in,
  output card_host_pkg::slot_out_type slot_b_out,
  input wire card_host_pkg::slot_in_type slot_b_in
);
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CMD = 3'h1, ST_RSP_WAIT = 3'h2,
    ST_RSP = 3'h3, ST_RSP_CHK = 3'h4, ST_DAT = 3'h5
  } state_type;
  // Phases inside one data block.
  typedef enum logic [2:0] {
    DP_START = 3'h0, DP_WAIT = 3'h1, DP_WORD = 3'h2,
    DP_END = 3'h3, DP_REL = 3'h4
  } dphase_type;

  // Computes the 7-bit frame checksum, polynomial x^7 + x^3 + 1.
  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ 7'h09;
      end
    end
    return c;
  endfunction

  state_type state_q;  // Sequencer state.
  dphase_type dph_q;  // Data phase.
  card_host_pkg::cmd_req_type req_q;  // Command in flight.
  card_host_pkg::status_type status_q;  // Registered status.
  card_host_pkg::slot_in_type sa1_q, sa2_q, sb1_q, sb2_q;  // Synchronisers.
  card_host_pkg::slot_in_type pin_in;  // Synchronised selected slot.
  card_host_pkg::slot_out_type slot_a_q, slot_b_q;  // Pin drive registers.
  logic [7:0] div_cnt_q;  // Card clock half-period counter.
  logic clk_q;  // Card clock level.
  logic tick;  // Rising edge of the card clock in this cycle.
  logic stall;  // Holds the card clock while the buffer blocks.
  logic [47:0] cmd_sr_q, rsp_sr_q, resp_q;  // Frame shifters.
  logic [5:0] bcnt_q;  // Bit counter.
  logic [15:0] tcnt_q, wcnt_q, blk_left_q;  // Timeout, word, block counts.
  logic [31:0] dsr_q;  // Data word shifter.
  logic cmd_bit_q, cmd_drv_q;  // Command line level and drive.
  logic [3:0] dat_bits_q, dat_drv_q;  // Data line levels and drive.
  logic push_q;  // Received word waits for the buffer.
  logic [31:0] push_data_q;
  logic stop_q;  // Stop asked for an open-ended transfer.
  logic width4;  // Four data lines in use.
  logic [3:0] lane_mask;
  logic [5:0] chunk;  // Bits moved per card clock.
  logic last_chunk, more_words, need_load, pop, en;
  logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [31:0] fifo_in_data, fifo_out_data;

  assign en = interface_enable_bit;
  assign width4 = sd_mode && bus_width_select;
  assign lane_mask = width4 ? 4'hf : 4'h1;
  assign chunk = width4 ? 6'h04 : 6'h01;
  assign last_chunk = (bcnt_q == card_host_pkg::WORD_BITS - chunk);
  assign more_words = (wcnt_q + 16'h0001) != req_q.blk_words;
  assign need_load = (dph_q == DP_START) ||
                     ((dph_q == DP_WORD) && last_chunk && more_words);
  assign pin_in = (slot_sel == card_host_pkg::SLOT_A) ? sa2_q : sb2_q;
  // buffer back-pressure stops the card clock.
  assign stall = (state_q == ST_DAT) && (req_q.xfer_write ?
                 (need_load && !fifo_out_valid) :
                 ((dph_q == DP_WORD) && !fifo_in_ready));
  assign tick = en && !stall && !clk_q && (div_cnt_q >= clk_div);
  assign pop = tick && (state_q == ST_DAT) && req_q.xfer_write && need_load;

  // Buffer sides follow the transfer direction.
  assign fifo_in_valid = req_q.xfer_write ? dma_wr_valid : push_q;
  assign fifo_in_data = req_q.xfer_write ? dma_wr_data : push_data_q;
  assign dma_wr_ready = req_q.xfer_write && fifo_in_ready;
  assign fifo_out_ready = req_q.xfer_write ? pop : dma_rd_ready;
  assign dma_rd_valid = !req_q.xfer_write && fifo_out_valid;
  assign dma_rd_data = fifo_out_data;
  assign status = status_q;
  assign resp = resp_q;
  assign card_bus_clock_pin = clk_q;
  assign slot_a_out = slot_a_q;
  assign slot_b_out = slot_b_q;
  // card detect seen on data line three.
  assign card_detect_a = sa2_q.dat_i[3];
  assign card_detect_b = sb2_q.dat_i[3];

  fifo_buf #(.WIDTH(32), .DEPTH(card_host_pkg::FIFO_DEPTH)) u_fifo (
    .mclk(mclk), .rstn(rstn),
    .in_valid(fifo_in_valid), .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(fifo_out_valid), .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Two-stage synchronisers for both slots' input pins.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sa1_q <= '1;
      sa2_q <= '1;
      sb1_q <= '1;
      sb2_q <= '1;
    end else begin
      sa1_q <= slot_a_in;
      sa2_q <= sa1_q;
      sb1_q <= slot_b_in;
      sb2_q <= sb1_q;
    end
  end

  // Divider count that the card clock starts from after reset or disable.
  localparam logic [7:0] CLK_DIV_RESET_L = card_host_pkg::CLK_DIV_RESET;

  // Card clock divider; each half period lasts clk_div + 1 cycles.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      div_cnt_q <= CLK_DIV_RESET_L;
      clk_q <= 1'b0;
    end else if (!en) begin
      div_cnt_q <= CLK_DIV_RESET_L;
      clk_q <= 1'b0;
    end else if (!stall) begin
      // toggling no faster than every cycle.
      if (div_cnt_q >= clk_div) begin
        div_cnt_q <= 8'h00;
        clk_q <= ~clk_q;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end

  // Command, response and data sequencer; shift, wait and data states step on card clock rises.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      dph_q <= DP_START;
      req_q <= '0;
      status_q <= '0;
      cmd_sr_q <= '0;
      rsp_sr_q <= '0;
      resp_q <= '0;
      bcnt_q <= 6'h00;
      tcnt_q <= 16'h0000;
      wcnt_q <= 16'h0000;
      blk_left_q <= 16'h0000;
      dsr_q <= 32'h0000_0000;
      cmd_bit_q <= 1'b1;
      cmd_drv_q <= 1'b0;
      dat_bits_q <= 4'hf;
      dat_drv_q <= 4'h0;
      push_q <= 1'b0;
      push_data_q <= 32'h0000_0000;
      stop_q <= 1'b0;
    end else if (!en) begin
      // disabled interface makes no bus activity.
      state_q <= ST_IDLE;
      cmd_drv_q <= 1'b0;
      dat_drv_q <= 4'h0;
      push_q <= 1'b0;
      status_q <= '0;
    end else begin
      status_q.cmd_done <= 1'b0;
      status_q.rsp_timeout <= 1'b0;
      status_q.rsp_crc_err <= 1'b0;
      status_q.data_timeout <= 1'b0;
      status_q.data_done <= 1'b0;
      status_q.busy <= (state_q != ST_IDLE);
      push_q <= 1'b0;
      if (stop_req) begin
        stop_q <= 1'b1;
      end
      unique case (state_q)
        // Takes a new command and frames it with index and checksum.
        ST_IDLE: begin
          if (cmd_start) begin
            req_q <= cmd_req;
            cmd_sr_q <= {2'b01, cmd_req.index, cmd_req.arg,
                         crc7({2'b01, cmd_req.index, cmd_req.arg}), 1'b1};
            bcnt_q <= 6'h00;
            tcnt_q <= 16'h0000;
            // A stop that arrives with the start is kept, not lost.
            stop_q <= stop_req;
            state_q <= ST_CMD;
          end
        end
        // shifts the command out by itself.
        ST_CMD: begin
          if (tick) begin
            if (bcnt_q == card_host_pkg::CMD_BITS) begin
              cmd_drv_q <= 1'b0;
              state_q <= (req_q.rsp == card_host_pkg::RSP_NONE) ?
                         ST_RSP_CHK : ST_RSP_WAIT;
            end else begin
              // command bit changes on the rise.
              cmd_drv_q <= 1'b1;
              cmd_bit_q <= cmd_sr_q[47];
              cmd_sr_q <= {cmd_sr_q[46:0], 1'b1};
              bcnt_q <= bcnt_q + 6'h01;
            end
          end
        end
        // response start bit watched with a timeout.
        ST_RSP_WAIT: begin
          if (tick) begin
            if (!pin_in.cmd_i) begin
              rsp_sr_q <= 48'h0;
              bcnt_q <= 6'h01;
              state_q <= ST_RSP;
            end else if (tcnt_q == RSP_TIMEOUT - 16'h0001) begin
              status_q.rsp_timeout <= 1'b1;
              status_q.cmd_done <= 1'b1;
              state_q <= ST_IDLE;
            end else begin
              tcnt_q <= tcnt_q + 16'h0001;
            end
          end
        end
        // Collects the rest of the response frame.
        ST_RSP: begin
          if (tick) begin
            rsp_sr_q <= {rsp_sr_q[46:0], pin_in.cmd_i};
            bcnt_q <= bcnt_q + 6'h01;
            if (bcnt_q == card_host_pkg::CMD_BITS - 6'h01) begin
              state_q <= ST_RSP_CHK;
            end
          end
        end
        // checks the response and starts any data phase.
        ST_RSP_CHK: begin
          status_q.cmd_done <= 1'b1;
          if (req_q.rsp != card_host_pkg::RSP_NONE) begin
            resp_q <= rsp_sr_q;
          end
          if ((req_q.rsp == card_host_pkg::RSP_CRC) &&
              (crc7(rsp_sr_q[47:8]) != rsp_sr_q[7:1])) begin
            status_q.rsp_crc_err <= 1'b1;
            state_q <= ST_IDLE;
          end else if (req_q.xfer) begin
            blk_left_q <= req_q.blk_count;
            tcnt_q <= 16'h0000;
            dph_q <= req_q.xfer_write ? DP_START : DP_WAIT;
            state_q <= ST_DAT;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        // block data in either direction through the buffer.
        ST_DAT: begin
          if (tick) begin
            unique case (dph_q)
              // Start bit on every active lane, first word loaded.
              DP_START: begin
                dat_drv_q <= lane_mask;
                dat_bits_q <= 4'h0;
                dsr_q <= fifo_out_data;
                bcnt_q <= 6'h00;
                wcnt_q <= 16'h0000;
                dph_q <= DP_WORD;
              end
              // Read: waits for the card's start bit on lane zero.
              DP_WAIT: begin
                if (!pin_in.dat_i[0]) begin
                  bcnt_q <= 6'h00;
                  wcnt_q <= 16'h0000;
                  tcnt_q <= 16'h0000;
                  dph_q <= DP_WORD;
                end else if (tcnt_q == DATA_TIMEOUT - 16'h0001) begin
                  status_q.data_timeout <= 1'b1;
                  state_q <= ST_IDLE;
                end else begin
                  tcnt_q <= tcnt_q + 16'h0001;
                end
              end
              // Moves one or four bits per rise, most significant first.
              DP_WORD: begin
                bcnt_q <= last_chunk ? 6'h00 : bcnt_q + chunk;
                if (req_q.xfer_write) begin
                  dat_bits_q <= width4 ? dsr_q[31:28] : {3'h7, dsr_q[31]};
                  dsr_q <= width4 ? {dsr_q[27:0], 4'h0} :
                           {dsr_q[30:0], 1'b0};
                  if (last_chunk && more_words) begin
                    dsr_q <= fifo_out_data;
                  end
                end else begin
                  // line one read as data during four-line transfers.
                  dsr_q <= width4 ? {dsr_q[27:0], pin_in.dat_i} :
                           {dsr_q[30:0], pin_in.dat_i[0]};
                  if (last_chunk) begin
                    push_q <= 1'b1;
                    push_data_q <= width4 ? {dsr_q[27:0], pin_in.dat_i} :
                                   {dsr_q[30:0], pin_in.dat_i[0]};
                  end
                end
                if (last_chunk) begin
                  wcnt_q <= wcnt_q + 16'h0001;
                  if (!more_words) begin
                    dph_q <= req_q.xfer_write ? DP_END : DP_REL;
                  end
                end
              end
              // End bit driven high.
              DP_END: begin
                dat_bits_q <= 4'hf;
                dph_q <= DP_REL;
              end
              // Releases the lanes and decides on the next block.
              DP_REL: begin
                dat_drv_q <= 4'h0;
                tcnt_q <= 16'h0000;
                if ((req_q.kind == card_host_pkg::XFER_SINGLE) ||
                    ((req_q.kind == card_host_pkg::XFER_MULTI) &&
                     (blk_left_q == 16'h0001)) ||
                    (((req_q.kind == card_host_pkg::XFER_STREAM) ||
                      (blk_left_q == 16'h0000)) && (stop_q || stop_req))) begin
                  status_q.data_done <= 1'b1;
                  state_q <= ST_IDLE;
                end else begin
                  if (blk_left_q != 16'h0000) begin
                    blk_left_q <= blk_left_q - 16'h0001;
                  end
                  dph_q <= req_q.xfer_write ? DP_START : DP_WAIT;
                end
              end
              default: begin
                dph_q <= DP_REL;
              end
            endcase
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Routes the drive to the selected slot only, other slot released.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slot_a_q <= '0;
      slot_b_q <= '0;
      card_irq <= 1'b0;
    end else begin
      slot_a_q <= '0;
      slot_b_q <= '0;
      // open-drain only pulls low; push-pull drives both.
      // open-drain lets up to thirty cards share the line.
      if (en && (slot_sel == card_host_pkg::SLOT_A)) begin
        slot_a_q.cmd_o <= req_q.open_drain ? 1'b0 : cmd_bit_q;
        slot_a_q.cmd_oe <= cmd_drv_q && !(req_q.open_drain && cmd_bit_q);
        slot_a_q.dat_o <= dat_bits_q & lane_mask;
        slot_a_q.dat_oe <= dat_drv_q & lane_mask;
      end
      if (en && (slot_sel == card_host_pkg::SLOT_B)) begin
        slot_b_q.cmd_o <= req_q.open_drain ? 1'b0 : cmd_bit_q;
        slot_b_q.cmd_oe <= cmd_drv_q && !(req_q.open_drain && cmd_bit_q);
        slot_b_q.dat_o <= dat_bits_q & lane_mask;
        slot_b_q.dat_oe <= dat_drv_q & lane_mask;
      end
      // line one low outside data in four-line mode means card interrupt.
      card_irq <= en && width4 && (state_q != ST_DAT) && !pin_in.dat_i[1];
    end
  end

  // Checks on the behaviour above.
  AST_CLK_HALF: assert property (@(posedge mclk) disable iff (!rstn)
    (en && !stall && div_cnt_q < clk_div) |=> $stable(clk_q))
    else $error("card clock half period shorter than the divider");
  AST_ONE_SLOT: assert property (@(posedge mclk) disable iff (!rstn)
    !((slot_a_q.cmd_oe || |slot_a_q.dat_oe) &&
      (slot_b_q.cmd_oe || |slot_b_q.dat_oe)))
    else $error("both slots driven at once");
  AST_SLOT_ROUTE: assert property (@(posedge mclk) disable iff (!rstn)
    (en && slot_sel == card_host_pkg::SLOT_A && cmd_drv_q &&
     !req_q.open_drain) |=> slot_a_q.cmd_oe)
    else $error("selected slot did not get the command drive");
  AST_UNSEL_IDLE: assert property (@(posedge mclk) disable iff (!rstn)
    (slot_sel != card_host_pkg::SLOT_B) |=>
    (!slot_b_q.cmd_oe && slot_b_q.dat_oe == 4'h0))
    else $error("unselected slot is driven");
  AST_WIDTH4: assert property (@(posedge mclk) disable iff (!rstn)
    (en && width4 && dat_drv_q[0] && slot_sel == card_host_pkg::SLOT_A)
    |=> slot_a_q.dat_oe == 4'hf)
    else $error("four-line mode did not drive all lanes");
  AST_MMC_LANE0: assert property (@(posedge mclk) disable iff (!rstn)
    !sd_mode |=> slot_a_q.dat_oe[3:1] == 3'h0)
    else $error("MMC mode drives lanes above zero");
  AST_DISABLED: assert property (@(posedge mclk) disable iff (!rstn)
    !en |=> (state_q == ST_IDLE && !clk_q && !slot_a_q.cmd_oe))
    else $error("activity while the interface is disabled");
  AST_OPEN_DRAIN: assert property (@(posedge mclk) disable iff (!rstn)
    (en && req_q.open_drain && slot_sel == card_host_pkg::SLOT_A)
    |=> slot_a_q.cmd_o == 1'b0)
    else $error("open-drain command line driven high");
  AST_RSP_TIMEOUT: assert property (@(posedge mclk) disable iff (!rstn)
    (en && state_q == ST_RSP_WAIT && tick && pin_in.cmd_i &&
     tcnt_q == RSP_TIMEOUT - 16'h0001)
    |=> (status_q.rsp_timeout && state_q == ST_IDLE))
    else $error("response timeout not reported");
  AST_CMD_ON_RISE: assert property (@(posedge mclk) disable iff (!rstn)
    $changed(cmd_bit_q) |-> $past(tick))
    else $error("command bit changed away from a card clock rise");
  AST_PUSH_ROOM: assert property (@(posedge mclk) disable iff (!rstn)
    (push_q && !req_q.xfer_write) |-> fifo_in_ready)
    else $error("received word dropped on a full buffer");
  AST_CARD_IRQ: assert property (@(posedge mclk) disable iff (!rstn)
    (en && width4 && state_q == ST_IDLE && !pin_in.dat_i[1])
    |=> card_irq)
    else $error("card interrupt on line one not reported");
endmodule

// [dv/card_model.sv]
// Behavioural card on one slot: pull-ups, detect, interrupt, frame capture.
module card_model (
  input wire logic card_bus_clock_pin,
  input wire card_host_pkg::slot_out_type pins,
  input wire logic present,
  input wire logic irq_req,
  output card_host_pkg::slot_in_type lines,
  output logic [47:0] frame,
  output logic [7:0] bits
);
  timeunit 1ns;
  timeprecision 1ns;
  initial bits = 8'h00;
  // Lines that nobody drives float high through the pull-ups; dat1 is pulled low by an interrupt request.
  // dat3 shows presence
  always_comb begin
    lines.cmd_i = pins.cmd_oe ? pins.cmd_o : 1'b1;
    lines.dat_i = ~pins.dat_oe | pins.dat_o;
    if (!pins.dat_oe[3]) lines.dat_i[3] = present;
    if (!pins.dat_oe[1]) lines.dat_i[1] = !irq_req;
  end
  always @(posedge card_bus_clock_pin) begin
    if (pins.cmd_oe) begin
      frame <= {frame[46:0], lines.cmd_i};
      bits <= bits + 8'h01;
    end
  end
endmodule

// [dv/card_host_interface_bench.sv]
// Self-checking bench for the card host interface.
module card_host_interface_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rstn = 0, en = 0, start = 0, sd = 0, wid = 0;
  logic cd = 1, irq = 0, ckp = 0, od_bad, xoe, done_s, to_s;
  logic wv = 0, dd = 0, wr_rdy;
  logic [3:0] lanes = 4'h0;
  logic [7:0] div = 8'h00;
  logic [31:0] wd = 32'h5a3c_e187;
  logic [1:0] sel = 2'h0;
  card_host_pkg::cmd_req_type req = '0;
  card_host_pkg::status_type st;
  card_host_pkg::slot_out_type ao, bo;
  card_host_pkg::slot_in_type ai, bi;
  logic ck, irq_o, cd_a, cd_b;
  logic [47:0] fa, fb;
  logic [7:0] na, nb;
  int err_total = 0, tests_run = 0, gap = 0, min_gap = 99;
  // Clock of 10 ns.
  always #5 mclk = ~mclk;
  card_host_interface dut (.mclk(mclk), .rstn(rstn),
    .interface_enable_bit(en), .clk_div(div), .slot_sel(sel),
    .sd_mode(sd), .bus_width_select(wid), .cmd_start(start),
    .cmd_req(req), .stop_req(1'b0), .status(st), .resp(),
    .dma_wr_valid(wv), .dma_wr_ready(wr_rdy), .dma_wr_data(wd),
    .dma_rd_valid(), .dma_rd_ready(1'b0), .dma_rd_data(),
    .card_irq(irq_o), .card_detect_a(cd_a), .card_detect_b(cd_b),
    .card_bus_clock_pin(ck), .slot_a_out(ao), .slot_a_in(ai),
    .slot_b_out(bo), .slot_b_in(bi));
  card_model card_a (.card_bus_clock_pin(ck), .pins(ao), .present(!cd),
    .irq_req(irq), .lines(ai), .frame(fa), .bits(na));
  card_model card_b (.card_bus_clock_pin(ck), .pins(bo), .present(cd),
    .irq_req(irq), .lines(bi), .frame(fb), .bits(nb));
  // Monitor: card clock period, pulses, open-drain and idle-slot drive.
  always @(posedge mclk) begin
    ckp <= ck;
    gap <= (ck && !ckp) ? 0 : gap + 1;
    if (ck && !ckp && gap + 1 < min_gap) min_gap <= gap + 1;
    if (st.cmd_done) done_s <= 1;
    if (st.rsp_timeout) to_s <= 1;
    if (st.data_done) dd <= 1;
    if (wv && wr_rdy) wv <= 0;
    lanes <= lanes | ao.dat_oe;
    if (req.open_drain && (ao.cmd_oe && ao.cmd_o)) od_bad <= 1;
    if (sel == 2'h0 && (bo.cmd_oe || bo.dat_oe != 0)) xoe <= 1;
    if (sel == 2'h1 && (ao.cmd_oe || ao.dat_oe != 0)) xoe <= 1;
  end
  task chk(input string name, input logic [47:0] seen, input logic [47:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Issue one command and wait for it to complete.
  task cmd(input logic [1:0] s, input logic [1:0] r, input logic od);
    int n;
    sel = s;
    req.rsp = card_host_pkg::rsp_kind_type'(r);
    req.open_drain = od;
    {done_s, to_s, od_bad, xoe} = 4'h0;
    start = 1;
    @(posedge mclk) #1 start = 0;
    n = 0;
    while (!((done_s | to_s) && !st.busy) && n < 3000) begin
      @(posedge mclk) #1 n++;
    end
    chk("cmd_wait", n < 3000, 1);
    repeat (4) @(posedge mclk);
    #1 chk("busy", st.busy, 0);
  endtask
  task final_report;
    if (err_total == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #300000 err_total++;
    final_report;
  end
  initial begin
    req.index = 6'h05;
    req.arg = 32'hc3a50f96;
    repeat (12) @(posedge mclk);
    #1 rstn = 1;
    start = 1;
    @(posedge mclk) #1 start = 0;
    repeat (20) @(posedge mclk);
    #1 chk("clk_idle", ck, 0);
    chk("busy_idle", st.busy, 0);
    chk("oe_idle", {ao.cmd_oe, ao.dat_oe}, 0);
    chk("detect_a", {cd_a, cd_b}, 1);
    en = 1;
    cmd(card_host_pkg::SLOT_A, 2'h0, 0);
    chk("a_bits", na, 48);
    chk("a_frame", fa[47:8], {2'b01, 6'h05, 32'hc3a50f96});
    chk("a_end", fa[0], 1);
    chk("a_done", done_s, 1);
    chk("b_quiet", xoe, 0);
    chk("rate", min_gap >= card_host_pkg::CARD_CLK_MIN_DIV, 1);
    div = 8'h01;
    cmd(card_host_pkg::SLOT_B, 2'h1, 0);
    chk("b_bits", nb, 48);
    chk("a_still", na, 48);
    chk("a_quiet", xoe, 0);
    chk("timeout", to_s, 1);
    div = 8'h00;
    cmd(card_host_pkg::SLOT_A, 2'h0, 1);
    chk("od_high", od_bad, 0);
    chk("od_drive", na > 48, 1);
    req.xfer = 1;
    req.xfer_write = 1;
    req.blk_words = 16'h0001;
    // One-word block write, first on one lane, then on four lanes.
    for (int w = 0; w < 2; w++) begin
      {sd, wid, wv, lanes, dd} = {w[0], w[0], 1'b1, 4'h0, 1'b0};
      cmd(card_host_pkg::SLOT_A, 2'h0, 0);
      if (w == 0) chk("mmc_lanes", lanes, 4'h1);
      else chk("sd4_lanes", lanes, 4'hf);
      chk("wr_done", {dd, wv}, 2'b10);
    end
    cd = 0;
    {sd, wid, irq} = 3'h7;
    repeat (6) @(posedge mclk);
    #1 chk("detect_b", {cd_a, cd_b}, 2);
    chk("irq_on", irq_o, 1);
    wid = 0;
    repeat (6) @(posedge mclk);
    #1 chk("irq_one_lane", irq_o, 0);
    en = 0;
    repeat (6) @(posedge mclk);
    #1 chk("clk_off", ck, 0);
    final_report;
  end
endmodule
